// >>> logic/bcd_counter_params.svh
// Offsets, field positions, reset values and decade limits of the BCD counter.
// Assumes inclusion by bare name from the package and the top module.
`ifndef BCD_COUNTER_PARAMS_SVH
`define BCD_COUNTER_PARAMS_SVH

// Register byte addresses
`define REG_CTRL_ADDR       8'h00
`define REG_PRESET_ADDR     8'h04
`define REG_STATUS_ADDR     8'h08
`define REG_WRAPS_ADDR      8'h0c

// Control fields
`define CTRL_SW_LOAD_BIT    0
`define CTRL_SW_INHIBIT_BIT 1
`define CTRL_SW_DIR_EN_BIT  2
`define CTRL_SW_DIR_BIT     3

// Status fields
`define STAT_COUNT_LSB      0
`define STAT_LIMIT_BIT      4
`define STAT_RIPPLE_BIT     5
`define STAT_DIR_BIT        6
`define STAT_GATE_BIT       7
`define STAT_LOAD_BIT       8
`define STAT_PIN_PRESET_LSB 12

// Reset values
`define CTRL_RESET          4'h0
`define PRESET_RESET        4'h0
`define COUNT_RESET         4'h0
`define WRAPS_RESET         8'h00
`define PIN_SYNC_RESET      8'h0a

// Decade limits
`define BCD_TOP             4'h9
`define BCD_BOTTOM          4'h0

`endif

// >>> logic/bcd_counter_pkg.sv
// Types and decade arithmetic shared by the BCD counter modules.
// Assumes the params header is on the include path.
`default_nettype none
package bcd_counter_pkg;
  `include "bcd_counter_params.svh"

  typedef logic [3:0]  bcd_t;
  typedef logic [7:0]  apb_addr_t;
  typedef logic [31:0] apb_data_t;

  typedef enum logic [0:0] {
    APB_IDLE = 1'b0,
    APB_ACK  = 1'b1
  } apb_state_e;

  typedef enum logic [0:0] {
    RIP_IDLE = 1'b0,
    RIP_LOW  = 1'b1
  } ripple_state_e;

  function automatic bcd_t bcdNext(input bcd_t cur, input logic down);
    bcd_t nxt;
    if (!down) begin
      nxt = (cur >= `BCD_TOP) ? `BCD_BOTTOM : bcd_t'(cur + 4'h1);
    end else begin
      nxt = (cur == `BCD_BOTTOM) ? `BCD_TOP : bcd_t'(cur - 4'h1);
    end
    return nxt;
  endfunction : bcdNext

  function automatic logic isLimit(input bcd_t cur, input logic down);
    return down ? (cur == `BCD_BOTTOM) : (cur == `BCD_TOP);
  endfunction : isLimit
endpackage : bcd_counter_pkg
`default_nettype wire

// >>> logic/ripple_link_if.sv
// Carrier between the counter top and its ripple pulse generator.
// Assumes all members are driven on clk; the pulse comes back from the gen side.
`timescale 1ns/1ps
`default_nettype none
interface ripple_link_if;
  logic clkRise;
  logic clkFall;
  logic gateOn;
  logic limitOn;
  logic loadOn;
  logic rippleN;

  modport src (output clkRise, output clkFall, output gateOn, output limitOn, output loadOn, input rippleN);
  modport gen (input clkRise, input clkFall, input gateOn, input limitOn, input loadOn, output rippleN);
endinterface : ripple_link_if
`default_nettype wire

// >>> logic/pin_sync.sv
// Two flip-flop synchroniser for a group of asynchronous pins.
// Assumes each bit is independent; no bus coherence across bits.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int               WIDTH     = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,      // System clock
  input  wire logic             sys_rst,  // Async reset, high
  input  wire logic [WIDTH-1:0] pinAsync, // Raw pins
  output logic      [WIDTH-1:0] pinSync   // Synchronised pins
);
  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1_q <= RESET_VAL;
      stage2_q <= RESET_VAL;
    end else begin
      stage1_q <= pinAsync;
      stage2_q <= stage1_q;
    end
  end

  assign pinSync = stage2_q;
endmodule : pin_sync
`default_nettype wire

// >>> logic/ripple_gate.sv
// Ripple pulse generator: low for the count clock's low phase at a limit.
// Assumes edges and conditions arrive already synchronised on clk.
`timescale 1ns/1ps
`default_nettype none
module ripple_gate (
  input  wire logic  clk,     // System clock
  input  wire logic  sys_rst, // Async reset, high
  ripple_link_if.gen link     // Edges and conditions in, pulse out
);
  import bcd_counter_pkg::*;

  ripple_state_e state_q;
  ripple_state_e state_d;
  logic          rippleN_q;
  wire           condOn;

  assign condOn = link.gateOn & link.limitOn & ~link.loadOn;

  always_comb begin
    state_d = state_q;
    case (state_q)
      RIP_IDLE: begin
        if (link.clkFall && condOn) begin
          state_d = RIP_LOW;
        end
      end
      RIP_LOW: begin
        if (link.clkRise || !condOn) begin
          state_d = RIP_IDLE;
        end
      end
      default: begin
        state_d = RIP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q   <= RIP_IDLE;
      rippleN_q <= 1'b1;
    end else begin
      state_q   <= state_d;
      rippleN_q <= (state_d != RIP_LOW);
    end
  end

  assign link.rippleN = rippleN_q;
endmodule : ripple_gate
`default_nettype wire

// >>> logic/bcd_updown_counter_ripple.sv
// Reversible BCD decade counter with preset, terminal flag and ripple pulse,
// with an APB slave for software override and status.
// Assumes all pin inputs are asynchronous to clk and change slower than clk.
//
// Functional notes
// - Four-bit count in 8421 BCD, cycling zero to nine either way.
// - Load low copies preset into count, overriding counting, regardless of clock.
// - Gate high with load high keeps the count unchanged.
// - Gate low, load high: count advances only on count clock rising edge.
// - Direction low counts up, high counts down, sampled at the rising edge.
// - Limit flag high at nine counting up or zero counting down.
// - Limit flag holds until count changes or direction changes.
// - Limit flag depends on count and direction only, not the gate.
// - With gate low and limit high, ripple goes low at next clock fall.
// - Ripple forced high when gate high, limit low, or load low.
// - Ripple returns high promptly after the count clock rises.
`timescale 1ns/1ps
`default_nettype none
`include "bcd_counter_params.svh"
module bcd_updown_counter_ripple (
  input  wire logic                        clk,            // System clock
  input  wire logic                        sys_rst,        // Async reset, high
  input  wire bcd_counter_pkg::apb_addr_t  paddr,          // APB address
  input  wire logic                        psel,           // APB select
  input  wire logic                        penable,        // APB enable
  input  wire logic                        pwrite,         // APB direction
  input  wire bcd_counter_pkg::apb_data_t  pwdata,         // APB write data
  input  wire logic [3:0]                  pstrb,          // APB byte strobes
  output var  bcd_counter_pkg::apb_data_t  prdata,         // APB read data
  output var  logic                        pready,         // APB ready
  output var  logic                        pslverr,        // APB error
  input  wire logic                        count_clk,      // Count clock pin
  input  wire logic                        count_gate_n,   // Count gate, low enables
  input  wire logic                        direction_sel,  // Low up, high down
  input  wire logic                        load_n,         // Preset load, low active
  input  wire bcd_counter_pkg::bcd_t       preset_value,   // Preset data
  output var  bcd_counter_pkg::bcd_t       count_value,    // Current count
  output var  logic                        limit_reached,  // Terminal count flag
  output var  logic                        ripple_pulse_n  // Ripple pulse, low active
);
  import bcd_counter_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0]    pinRaw;
  logic [7:0]    pinSync;
  wire           countClkSync;
  wire           gateNSync;
  wire           dirSync;
  wire           loadNSync;
  bcd_t          presetSync;
  logic          countClkPrev_q;
  wire           clkRise;
  wire           clkFall;

  logic [3:0]    ctrl_q;
  bcd_t          swPreset_q;
  logic [7:0]    wraps_q;
  logic [7:0]    wraps_d;

  bcd_t          countValue_q;
  bcd_t          countValue_d;
  logic          limitReached_q;
  logic          limitReached_d;

  wire           swLoad;
  wire           swInhibit;
  wire           swDirEn;
  wire           swDir;
  wire           dirEff;
  wire           gateOn;
  wire           loadOn;
  bcd_t          presetEff;
  wire           countStep;
  wire           wrapEvent;
  wire           wrapsClear;
  wire           ctrlWrite;
  wire           presetWrite;

  apb_state_e    apbState_q;
  apb_state_e    apbState_d;
  logic          pready_q;
  apb_data_t     prdata_q;
  logic          pslverr_q;
  wire           setupPhase;
  wire           accessDone;
  wire           writeEn;
  wire           lane0;
  wire           hitCtrl;
  wire           hitPreset;
  wire           hitStatus;
  wire           hitWraps;
  wire           addrHit;
  apb_data_t     statusWord;
  apb_data_t     readData;

  ripple_link_if link ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and count clock edges

  assign pinRaw = {preset_value, load_n, direction_sel, count_gate_n, count_clk};

  // One synchroniser for the group; bits may land a cycle apart
  // inputs may move any phase
  pin_sync #(
    .WIDTH     (8),
    .RESET_VAL (`PIN_SYNC_RESET)
  ) u_pin_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pinAsync (pinRaw),
    .pinSync  (pinSync)
  );

  assign countClkSync = pinSync[0];
  assign gateNSync    = pinSync[1];
  assign dirSync      = pinSync[2];
  assign loadNSync    = pinSync[3];
  assign presetSync   = pinSync[7:4];

  // Idle-low reset matches the pin's idle level, so no false rise follows reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      countClkPrev_q <= 1'b0;
    end else begin
      countClkPrev_q <= countClkSync;
    end
  end

  assign clkRise = countClkSync & ~countClkPrev_q;
  assign clkFall = ~countClkSync & countClkPrev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Effective controls: pins combined with software overrides

  assign swLoad    = ctrl_q[`CTRL_SW_LOAD_BIT];
  assign swInhibit = ctrl_q[`CTRL_SW_INHIBIT_BIT];
  assign swDirEn   = ctrl_q[`CTRL_SW_DIR_EN_BIT];
  assign swDir     = ctrl_q[`CTRL_SW_DIR_BIT];

  assign dirEff    = swDirEn ? swDir : dirSync;
  assign gateOn    = ~gateNSync & ~swInhibit;
  // Software load wins so a driver can freeze a preset without the pin
  assign loadOn    = ~loadNSync | swLoad;
  assign presetEff = swLoad ? swPreset_q : presetSync;

  assign countStep = clkRise & gateOn & ~loadOn;
  assign wrapEvent = countStep & isLimit(countValue_q, dirEff);

  ////////////////////////////////////////////////////////////////////////////
  // Decade counter

  always_comb begin
    countValue_d = countValue_q;
    if (loadOn) begin
      countValue_d = presetEff;
    end else if (countStep) begin
      countValue_d = bcdNext(countValue_q, dirEff);
    end
  end

  assign limitReached_d = isLimit(countValue_d, dirEff);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      countValue_q   <= `COUNT_RESET;
      limitReached_q <= 1'b0;
    end else begin
      countValue_q   <= countValue_d;
      limitReached_q <= limitReached_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ripple pulse

  assign link.clkRise = clkRise;
  assign link.clkFall = clkFall;
  assign link.gateOn  = gateOn;
  // Registered flag keeps the pulse aligned with the visible limit output
  assign link.limitOn = limitReached_q;
  assign link.loadOn  = loadOn;

  ripple_gate u_ripple_gate (
    .clk     (clk),
    .sys_rst (sys_rst),
    .link    (link.gen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  // Full-word compare; a partial decode would alias unmapped offsets
  function automatic logic addrIs(input apb_addr_t a, input apb_addr_t target);
    return (a == target);
  endfunction : addrIs

  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & pready_q;
  assign writeEn    = accessDone & pwrite;
  assign lane0      = pstrb[0];

  assign hitCtrl    = addrIs(paddr, `REG_CTRL_ADDR);
  assign hitPreset  = addrIs(paddr, `REG_PRESET_ADDR);
  assign hitStatus  = addrIs(paddr, `REG_STATUS_ADDR);
  assign hitWraps   = addrIs(paddr, `REG_WRAPS_ADDR);
  assign addrHit    = hitCtrl | hitPreset | hitStatus | hitWraps;

  // Byte lane 0 carries every writable field
  assign ctrlWrite   = writeEn & lane0 & hitCtrl;
  assign presetWrite = writeEn & lane0 & hitPreset;
  assign wrapsClear  = writeEn & lane0 & hitWraps;

  always_comb begin
    statusWord                            = 32'h00000000;
    statusWord[`STAT_COUNT_LSB +: 4]      = countValue_q;
    statusWord[`STAT_LIMIT_BIT]           = limitReached_q;
    statusWord[`STAT_RIPPLE_BIT]          = link.rippleN;
    statusWord[`STAT_DIR_BIT]             = dirEff;
    statusWord[`STAT_GATE_BIT]            = gateOn;
    statusWord[`STAT_LOAD_BIT]            = loadOn;
    statusWord[`STAT_PIN_PRESET_LSB +: 4] = presetSync;
  end

  assign readData   = hitCtrl   ? {28'h0000000, ctrl_q}     :
                      hitPreset ? {28'h0000000, swPreset_q} :
                      hitStatus ? statusWord                :
                      hitWraps  ? {24'h000000, wraps_q}     :
                                  32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: one access cycle, answer prepared at setup
  // Limitation: pready rises one cycle after every setup taken in APB_IDLE, whether or not penable follows

  always_comb begin
    apbState_d = apbState_q;
    case (apbState_q)
      APB_IDLE: begin
        if (setupPhase) begin
          apbState_d = APB_ACK;
        end
      end
      APB_ACK: begin
        apbState_d = APB_IDLE;
      end
      default: begin
        apbState_d = APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      apbState_q <= APB_IDLE;
      pready_q   <= 1'b0;
    end else begin
      apbState_q <= apbState_d;
      pready_q   <= (apbState_d == APB_ACK);
    end
  end

  // Data and error latched at setup so they stand through the access cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_q   <= 32'h00000000;
      pslverr_q  <= 1'b0;
    end else begin
      if (setupPhase) begin
        prdata_q  <= pwrite ? 32'h00000000 : readData;
        pslverr_q <= ~addrHit;
      end else if (accessDone) begin
        prdata_q  <= 32'h00000000;
        pslverr_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q     <= `CTRL_RESET;
      swPreset_q <= `PRESET_RESET;
    end else begin
      if (ctrlWrite) begin
        ctrl_q <= pwdata[3:0];
      end
      if (presetWrite) begin
        swPreset_q <= pwdata[3:0];
      end
    end
  end

  // Carry tally; a carry in the clearing cycle survives as one
  always_comb begin
    wraps_d = wraps_q;
    if (wrapsClear) begin
      wraps_d = `WRAPS_RESET;
    end
    if (wrapEvent) begin
      wraps_d = 8'(wraps_d + 8'h01);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wraps_q <= `WRAPS_RESET;
    end else begin
      wraps_q <= wraps_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Every pin comes straight from a flop, so no decode spike leaves the block
  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign count_value    = countValue_q;
  assign limit_reached  = limitReached_q;
  assign ripple_pulse_n = link.rippleN;
endmodule : bcd_updown_counter_ripple
`default_nettype wire

// >>> verification/bcd_counter_checker.sv
// Port-level assertions for the BCD counter top, bound to every instance.
// Assumes pin phases of four or more clk cycles and no software load that moves the count.
`timescale 1ns/1ps
`default_nettype none
module bcd_counter_checker (
  input wire logic                       clk,            // System clock
  input wire logic                       sys_rst,        // Async reset
  input wire logic                       psel,           // APB select
  input wire logic                       penable,        // APB enable
  input wire bcd_counter_pkg::apb_data_t prdata,         // APB read data
  input wire logic                       pready,         // APB ready
  input wire logic                       pslverr,        // APB error
  input wire logic                       count_clk,      // Count clock pin
  input wire logic                       count_gate_n,   // Gate, low enables
  input wire logic                       load_n,         // Preset load
  input wire bcd_counter_pkg::bcd_t      preset_value,   // Preset data
  input wire bcd_counter_pkg::bcd_t      count_value,    // Count
  input wire logic                       limit_reached,  // Terminal flag
  input wire logic                       ripple_pulse_n  // Ripple pulse
);
  import bcd_counter_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_idle_quiet: assert property (!pready |-> !pslverr && prdata == 32'h0)
    else $error("error or data outside access");
  chk_limit_code: assert property (limit_reached |-> count_value == 4'h9 || count_value == 4'h0)
    else $error("limit flag at a middle count");
  chk_ripple_fall: assert property ($fell(ripple_pulse_n) |->
    limit_reached && load_n && !$past(count_clk) && !$past(count_gate_n, 2))
    else $error("ripple fell without cause");
  chk_ripple_rise: assert property ($rose(count_clk) |-> ##[1:5] ripple_pulse_n)
    else $error("ripple not released after clock rise");
  chk_step_cause: assert property (load_n && $past(load_n, 2) && $past(load_n, 3) && $past(load_n, 4)
    && $changed(count_value) |-> $past(count_clk, 2) && !$past(count_clk, 5) && !$past(count_gate_n, 3))
    else $error("count moved without gated clock rise");
  // Five samples cover the three-edge pin latency with margin
  chk_load_copy: assert property ((!load_n && $stable(preset_value)) [*5] |-> count_value == preset_value)
    else $error("count does not follow preset");
endmodule : bcd_counter_checker

bind bcd_updown_counter_ripple bcd_counter_checker chk (.clk, .sys_rst, .psel, .penable, .prdata, .pready,
  .pslverr, .count_clk, .count_gate_n, .load_n, .preset_value, .count_value, .limit_reached, .ripple_pulse_n);
`default_nettype wire

// >>> verification/bcd_pin_driver.sv
// Control logic model that drives the counter pins.
// Assumes calls from the bench; all pins move by NBA after a clk edge.
`timescale 1ns/1ps
`default_nettype none
module bcd_pin_driver (
  input  wire logic                  clk,           // System clock
  output var  logic                  count_clk,     // Counted clock
  output var  logic                  count_gate_n,  // Gate, low enables
  output var  logic                  direction_sel, // Low up, high down
  output var  logic                  load_n,        // Preset load
  output var  bcd_counter_pkg::bcd_t preset_value   // Preset data
);
  import bcd_counter_pkg::*;
  initial begin
    count_clk     = 1'b0;
    count_gate_n  = 1'b1;
    direction_sel = 1'b0;
    load_n        = 1'b1;
    preset_value  = 4'h0;
  end
  // controls move only mid low phase
  task automatic setPins(input logic g, input logic d);
    repeat (2) @(posedge clk);
    count_gate_n  <= g;
    direction_sel <= d;
    repeat (6) @(posedge clk);
  endtask : setPins
  // gate formed from one preceding limit flag and a global enable
  task automatic gateFrom(input logic en, input logic prevLimit, input logic d);
    setPins(~(en & prevLimit), d);
  endtask : gateFrom
  // clock never taken from limit; low phase kept long
  task automatic pulse(input int n, input int ph);
    repeat (n) begin
      @(posedge clk);
      count_clk <= 1'b1;
      repeat (ph) @(posedge clk);
      count_clk <= 1'b0;
      repeat (ph) @(posedge clk);
    end
  endtask : pulse
  task automatic load(input bcd_t v);
    @(posedge clk);
    preset_value <= v;
    load_n       <= 1'b0;
    repeat (8) @(posedge clk);
    load_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : load
endmodule : bcd_pin_driver
`default_nettype wire

// >>> verification/bcd_updown_counter_ripple_tb.sv
// Self-checking bench: APB register calls and pin sequences with expectations.
// Assumes the checker is bound through its own file.
`timescale 1ns/1ps
`default_nettype none
`include "bcd_counter_params.svh"
module bcd_updown_counter_ripple_tb;
  import bcd_counter_pkg::*;
  logic       clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  apb_addr_t  paddr;
  apb_data_t  pwdata, prdata;
  logic [3:0] pstrb;
  logic       count_clk, count_gate_n, direction_sel, load_n, limit_reached, ripple_pulse_n;
  bcd_t       preset_value, count_value;
  int         errCount   = 0;
  int         checksDone = 0;

  bcd_updown_counter_ripple dut (.clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .count_clk, .count_gate_n, .direction_sel, .load_n, .preset_value,
    .count_value, .limit_reached, .ripple_pulse_n);
  bcd_pin_driver pins (.clk, .count_clk, .count_gate_n, .direction_sel, .load_n, .preset_value);

  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic outs(input bcd_t c, input logic l, input logic r);
    #1;
    check("count", {28'h0, c}, {28'h0, count_value});
    check("limit", {31'h0, l}, {31'h0, limit_reached});
    check("ripple", {31'h0, r}, {31'h0, ripple_pulse_n});
  endtask : outs
  // Holds the request until pready is sampled high
  task automatic apb(input logic w, input apb_addr_t a, input apb_data_t d, output apb_data_t r, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= 4'hf;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input apb_addr_t a, input apb_data_t d);
    apb_data_t r;
    logic      e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input apb_addr_t a, input apb_data_t x, input logic xe, input string what);
    apb_data_t r;
    logic      e;
    apb(1'b0, a, 32'h0, r, e);
    check(what, x, r);
    check("slave error", {31'h0, xe}, {31'h0, e});
  endtask : rd
  task automatic done(input string name);
    $display("test %s finished, mismatches so far %0d", name, errCount);
  endtask : done
  task automatic endOfTest();
    $display("comparisons %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : endOfTest

  ////////////////////////////////////////////////////////////////
  initial begin
    #(20000 * 8);
    errCount++;
    endOfTest();
  end

  initial begin
    clk     = 1'b0;
    sys_rst = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    outs(4'h0, 1'b0, 1'b1);
    rd(`REG_STATUS_ADDR, 32'h20, 1'b0, "status");
    wr(`REG_PRESET_ADDR, 32'h5);
    rd(`REG_PRESET_ADDR, 32'h5, 1'b0, "preset reg");
    rd(8'h10, 32'h0, 1'b1, "unmapped");
    done("registers");
    pins.setPins(1'b0, 1'b0);
    pins.load(4'h7);
    outs(4'h7, 1'b0, 1'b1);
    pins.pulse(2, 8);
    outs(4'h9, 1'b1, 1'b0);
    pins.pulse(1, 8);
    outs(4'h0, 1'b0, 1'b1);
    rd(`REG_WRAPS_ADDR, 32'h1, 1'b0, "wraps up");
    done("count up");
    pins.setPins(1'b0, 1'b1);
    outs(4'h0, 1'b1, 1'b1);
    pins.gateFrom(1'b1, 1'b0, 1'b1);
    pins.pulse(2, 8);
    outs(4'h0, 1'b1, 1'b1);
    pins.setPins(1'b0, 1'b1);
    pins.pulse(1, 8);
    outs(4'h9, 1'b0, 1'b1);
    pins.pulse(3, 4);
    outs(4'h6, 1'b0, 1'b1);
    rd(`REG_WRAPS_ADDR, 32'h2, 1'b0, "wraps down");
    done("count down");
    pins.setPins(1'b0, 1'b0);
    pins.load(4'hc);
    outs(4'hc, 1'b0, 1'b1);
    pins.pulse(1, 8);
    outs(4'h0, 1'b0, 1'b1);
    pins.load(4'hc);
    pins.setPins(1'b0, 1'b1);
    pins.pulse(1, 8);
    outs(4'hb, 1'b0, 1'b1);
    done("codes above nine");
    wr(`REG_CTRL_ADDR, 32'h2);
    rd(`REG_CTRL_ADDR, 32'h2, 1'b0, "control");
    pins.pulse(1, 8);
    outs(4'hb, 1'b0, 1'b1);
    wr(`REG_CTRL_ADDR, 32'h4);
    pins.pulse(1, 8);
    outs(4'h0, 1'b0, 1'b1);
    wr(`REG_PRESET_ADDR, 32'h0);
    wr(`REG_CTRL_ADDR, 32'h1);
    pins.pulse(1, 8);
    outs(4'h0, 1'b1, 1'b1);
    rd(`REG_STATUS_ADDR, 32'hc1f0, 1'b0, "status loaded");
    wr(`REG_CTRL_ADDR, 32'h0);
    wr(`REG_WRAPS_ADDR, 32'h0);
    rd(`REG_WRAPS_ADDR, 32'h0, 1'b0, "wraps cleared");
    done("software control");
    endOfTest();
  end
endmodule : bcd_updown_counter_ripple_tb
`default_nettype wire
